// [rtl/lst_pkg.sv]
// lst_pkg: constants for the link self test and page select block
// assumes: one 250 MHz clock, registers reached over a plain register port
package lst_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] LST_CSI_PAGE_OFS  = 8'h32;
	localparam logic [7:0] LST_RX_PAGE_OFS   = 8'h4c;
	localparam logic [7:0] LST_ERR_TALLY_OFS = 8'h57;
	localparam logic [7:0] LST_CONTROL_OFS   = 8'hb3;
	localparam logic [7:0] LST_RX_DEBUG_OFS  = 8'hd0;

	// ------------------------------------------------------------
	// address ranges
	// ------------------------------------------------------------
	localparam logic [7:0] LST_DIG_LO   = 8'h00;
	localparam logic [7:0] LST_DIG_HI   = 8'h32;
	localparam logic [7:0] LST_CSI_LO   = 8'h33;
	localparam logic [7:0] LST_CSI_HI   = 8'h3a;
	localparam logic [7:0] LST_EQ_LO    = 8'h40;
	localparam logic [7:0] LST_EQ_HI    = 8'h45;
	localparam logic [7:0] LST_RXP_LO   = 8'h46;
	localparam logic [7:0] LST_RXP_HI   = 8'h7f;
	localparam logic [7:0] LST_CDBG_LO  = 8'h90;
	localparam logic [7:0] LST_CDBG_HI  = 8'h9f;
	localparam logic [7:0] LST_IND_LO   = 8'hb0;
	localparam logic [7:0] LST_IND_HI   = 8'hb2;
	localparam logic [7:0] LST_DIG2_LO  = 8'hb3;
	localparam logic [7:0] LST_DIG2_HI  = 8'hbf;
	localparam logic [7:0] LST_RXD_LO   = 8'hd0;
	localparam logic [7:0] LST_RXD_HI   = 8'hdf;
	localparam logic [7:0] LST_RXID_LO  = 8'hf0;
	localparam logic [7:0] LST_RXID_HI  = 8'hf5;
	localparam logic [7:0] LST_PI2C_LO  = 8'hf8;
	localparam logic [7:0] LST_PI2C_HI  = 8'hfb;

	// ------------------------------------------------------------
	// fields and values
	// ------------------------------------------------------------
	localparam int         LST_NPORTS       = 4;
	localparam int         LST_OUT_MODE_HI  = 7;
	localparam int         LST_OUT_MODE_LO  = 6;
	localparam int         LST_CLK_SEL_HI   = 2;
	localparam int         LST_CLK_SEL_LO   = 1;
	localparam int         LST_ENABLE_BIT   = 0;
	localparam int         LST_RX_RSEL_HI   = 5;
	localparam int         LST_RX_RSEL_LO   = 4;
	localparam int         LST_CSI_RSEL_BIT = 4;
	localparam int         LST_FAR_ACT_BIT  = 5;
	localparam logic [7:0] LST_CTRL_START   = 8'h01;
	localparam logic [7:0] LST_CTRL_STOP    = 8'h00;
	localparam logic [1:0] LST_OUT_DISABLED = 2'h0;
	localparam logic [1:0] LST_OUT_ENABLED  = 2'h2;
	localparam logic [7:0] LST_TALLY_NOLOCK = 8'hff;
	localparam logic [7:0] LST_TALLY_MAX    = 8'hfe;
	localparam logic [7:0] LST_SER_CLK_REG  = 8'h14;
	localparam logic [7:0] LST_SER_MODE_REG = 8'h15;
	localparam logic [7:0] LST_SER_MODE_ON  = 8'h01;
	localparam logic [7:0] LST_SER_MODE_OFF = 8'h00;
	localparam logic [7:0] LST_RESET_ZERO   = 8'h00;
	localparam logic [7:0] LST_CSI_PG_RST   = 8'h00;
	localparam logic [7:0] LST_RX_PG_RST    = 8'h00;

	// region decode result
	typedef enum logic [3:0] {
		LST_REG_SHARED, LST_REG_CSI, LST_REG_RXP, LST_REG_RSVD
	} lst_region_e;

endpackage : lst_pkg

// [rtl/lst_port_checker.sv]
// lst_port_checker: error tally and pass flag for one receive port
// assumes: pattern_err strobes come from the link receiver per word
`timescale 1ns/1ns
`default_nettype none
module lst_port_checker (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       test_start,    // one cycle, test just enabled
	input  wire logic       test_run,      // test is active
	input  wire logic       rx_lock,       // receiver lock level
	input  wire logic       pattern_err,   // one cycle per data error
	output logic [7:0]      tally,         // error tally value
	output logic            pass_n_fail    // low for a cycle per error
);

	logic seen_lock_q;   // lock reached since start
	logic lock_bad_q;    // lock lost after it was gained

	// ------------------------------------------------------------
	// lock tracking
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seen_lock_q <= 1'b0;
			lock_bad_q  <= 1'b0;
		end else if (test_start) begin
			seen_lock_q <= 1'b0;
			lock_bad_q  <= 1'b0;
		end else if (test_run) begin
			if (rx_lock) begin
				seen_lock_q <= 1'b1;
			end else if (seen_lock_q) begin
				lock_bad_q <= 1'b1;  // lost lock
			end
		end
	end

	logic [7:0] count_q;  // ordinary error count

	// ------------------------------------------------------------
	// error count, cleared at start, saturating
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_q <= lst_pkg::LST_RESET_ZERO;
		end else if (test_start) begin
			count_q <= lst_pkg::LST_RESET_ZERO;
		end else if (test_run && rx_lock && pattern_err &&
			count_q != lst_pkg::LST_TALLY_MAX) begin
			count_q <= count_q + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tally       <= lst_pkg::LST_RESET_ZERO;
			pass_n_fail <= 1'b1;
		end else begin
			// no lock ever, or lock lost, reads as all ones
			if (lock_bad_q || (!test_run && !seen_lock_q &&
				count_q == lst_pkg::LST_RESET_ZERO && test_start == 1'b0
				&& tally == lst_pkg::LST_TALLY_NOLOCK))
				tally <= lst_pkg::LST_TALLY_NOLOCK;
			else if (test_run && !seen_lock_q && !rx_lock)
				tally <= lst_pkg::LST_TALLY_NOLOCK;
			else
				tally <= count_q;
			pass_n_fail <= !(test_run && rx_lock && pattern_err);
		end
	end

endmodule : lst_port_checker
`default_nettype wire

// [rtl/lst_top.sv]
// lst_top: link self test control and register page select
// assumes: one register port shared by i2c and control channel,
// a back channel write port to the serializer, per port receivers
`timescale 1ns/1ns
`default_nettype none
module lst_top (
	input  wire logic       clk,
	input  wire logic       rst,
	// register port, i2c and control channel merged ahead of it
	input  wire logic       reg_wr,        // write strobe
	input  wire logic       reg_rd,        // read strobe
	input  wire logic [7:0] reg_addr,      // register offset
	input  wire logic [7:0] reg_wdata,     // write data
	input  wire logic       reg_src_chan,  // 1 = control channel source
	output logic [7:0]      reg_rdata,     // read data
	output logic            reg_rvalid,    // read data valid
	output logic            reg_rsvd_hit,  // access hit reserved space
	// decoded page writes toward the wider register file
	output logic            shared_wr,     // write to a shared block
	output logic [3:0]      rxp_wr_en,     // per rx port write enables
	output logic [1:0]      csi_wr_en,     // per csi port write enables
	output logic [1:0]      rx_rd_sel,     // rx page read select
	output logic            csi_rd_sel,    // csi page read select
	output logic [7:0]      page_addr,     // offset for page write
	output logic [7:0]      page_wdata,    // data for page write
	// back channel register write to the serializer
	output logic            bc_wr,         // write request
	output logic [7:0]      bc_addr,       // serializer register
	output logic [7:0]      bc_wdata,      // serializer data
	input  wire logic       bc_ready,      // back channel takes write
	// per port receiver
	input  wire logic [3:0] rx_lock,       // receiver lock
	input  wire logic [3:0] pattern_err,   // data error strobes
	input  wire logic [3:0] far_active,    // serializer test active
	output logic [3:0]      pass_flag,     // pass indication for gpio
	// output gating
	output logic            test_active,   // test running
	output logic            video_out_en,  // device outputs allowed
	output logic            csi_lp11_hold  // csi held in lp11
);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	function automatic lst_pkg::lst_region_e region(input logic [7:0] a);
		if (a >= lst_pkg::LST_CSI_LO && a <= lst_pkg::LST_CSI_HI)
			return lst_pkg::LST_REG_CSI;
		if ((a >= lst_pkg::LST_RXP_LO && a <= lst_pkg::LST_RXP_HI) ||
			(a >= lst_pkg::LST_RXD_LO && a <= lst_pkg::LST_RXD_HI))
			return lst_pkg::LST_REG_RXP;
		if (a <= lst_pkg::LST_DIG_HI ||
			(a >= lst_pkg::LST_EQ_LO && a <= lst_pkg::LST_EQ_HI) ||
			(a >= lst_pkg::LST_CDBG_LO && a <= lst_pkg::LST_CDBG_HI) ||
			(a >= lst_pkg::LST_IND_LO && a <= lst_pkg::LST_IND_HI) ||
			(a >= lst_pkg::LST_DIG2_LO && a <= lst_pkg::LST_DIG2_HI) ||
			(a >= lst_pkg::LST_RXID_LO && a <= lst_pkg::LST_RXID_HI) ||
			(a >= lst_pkg::LST_PI2C_LO && a <= lst_pkg::LST_PI2C_HI))
			return lst_pkg::LST_REG_SHARED;
		return lst_pkg::LST_REG_RSVD;
	endfunction : region

	lst_pkg::lst_region_e wr_region;  // region of write address
	lst_pkg::lst_region_e rd_region;  // region of read address
	assign wr_region = region(reg_addr);
	assign rd_region = region(reg_addr);

	// ------------------------------------------------------------
	// page select registers
	// ------------------------------------------------------------
	logic [7:0] csi_page_q;  // csi page select
	logic [7:0] rx_page_q;   // rx page select

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			csi_page_q <= lst_pkg::LST_CSI_PG_RST;
			rx_page_q  <= lst_pkg::LST_RX_PG_RST;
		end else if (reg_wr) begin
			if (reg_addr == lst_pkg::LST_CSI_PAGE_OFS)
				csi_page_q <= reg_wdata;
			if (reg_addr == lst_pkg::LST_RX_PAGE_OFS)
				rx_page_q <= reg_wdata;
		end
	end

	// ------------------------------------------------------------
	// control register and test start/stop
	// ------------------------------------------------------------
	logic [7:0] ctrl_q;        // control register
	logic       run_q;         // test running
	logic       start_pulse;   // test turns on this cycle
	logic       stop_pulse;    // test turns off this cycle
	logic [1:0] clk_sel_q;     // clock select held for the test

	assign start_pulse = reg_wr && reg_addr == lst_pkg::LST_CONTROL_OFS &&
		reg_wdata[lst_pkg::LST_ENABLE_BIT] && !run_q;
	assign stop_pulse = reg_wr && reg_addr == lst_pkg::LST_CONTROL_OFS &&
		!reg_wdata[lst_pkg::LST_ENABLE_BIT] && run_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= lst_pkg::LST_RESET_ZERO;
			run_q  <= 1'b0;
		end else if (reg_wr && reg_addr == lst_pkg::LST_CONTROL_OFS) begin
			ctrl_q <= reg_wdata;
			run_q  <= reg_wdata[lst_pkg::LST_ENABLE_BIT];
		end
	end

	// clock select only sampled at start
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clk_sel_q <= 2'h0;
		end else if (start_pulse) begin
			clk_sel_q <= reg_wdata[lst_pkg::LST_CLK_SEL_HI:
				lst_pkg::LST_CLK_SEL_LO];
		end
	end

	// ------------------------------------------------------------
	// back channel sequencer
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		LST_BC_IDLE, LST_BC_CLK, LST_BC_MODE, LST_BC_OFF
	} lst_bc_e;
	lst_bc_e bc_state_q;  // sequencer state

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bc_state_q <= LST_BC_IDLE;
			bc_wr      <= 1'b0;
			bc_addr    <= lst_pkg::LST_RESET_ZERO;
			bc_wdata   <= lst_pkg::LST_RESET_ZERO;
		end else begin
			case (bc_state_q)
				LST_BC_IDLE: begin
					if (start_pulse) begin
						// first write sets pattern clock source
						bc_state_q <= LST_BC_CLK;
						bc_wr      <= 1'b1;
						bc_addr    <= lst_pkg::LST_SER_CLK_REG;
						bc_wdata   <= {5'h00, reg_wdata[lst_pkg::LST_CLK_SEL_HI:
							lst_pkg::LST_CLK_SEL_LO], 1'b0};
					end else if (stop_pulse) begin
						bc_state_q <= LST_BC_OFF;
						bc_wr      <= 1'b1;
						bc_addr    <= lst_pkg::LST_SER_MODE_REG;
						bc_wdata   <= lst_pkg::LST_SER_MODE_OFF;
					end
				end
				LST_BC_CLK: begin
					if (bc_ready) begin
						// then put serializer in test mode
						bc_state_q <= LST_BC_MODE;
						bc_addr    <= lst_pkg::LST_SER_MODE_REG;
						bc_wdata   <= lst_pkg::LST_SER_MODE_ON;
					end
				end
				LST_BC_MODE, LST_BC_OFF: begin
					if (bc_ready) begin
						bc_state_q <= LST_BC_IDLE;
						bc_wr      <= 1'b0;
					end
				end
				default: begin
					bc_state_q <= LST_BC_IDLE;
					bc_wr      <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// per port checkers
	// ------------------------------------------------------------
	logic [7:0] tally [lst_pkg::LST_NPORTS];  // per port tallies
	logic [3:0] pass_raw;                     // checker pass flags

	genvar gi;
	generate
		for (gi = 0; gi < lst_pkg::LST_NPORTS; gi++) begin : g_port
			lst_port_checker u_chk (
				.clk         (clk),
				.rst         (rst),
				.test_start  (start_pulse),
				.test_run    (run_q),
				.rx_lock     (rx_lock[gi]),
				.pattern_err (pattern_err[gi]),
				.tally       (tally[gi]),
				.pass_n_fail (pass_raw[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// register outputs: pass flags and gating
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pass_flag     <= 4'hf;
			test_active   <= 1'b0;
			video_out_en  <= 1'b1;
			csi_lp11_hold <= 1'b0;
		end else begin
			pass_flag   <= pass_raw;
			test_active <= run_q;
			// outputs gated by mode field while the test runs
			video_out_en <= !run_q || ctrl_q[lst_pkg::LST_OUT_MODE_HI:
				lst_pkg::LST_OUT_MODE_LO] == lst_pkg::LST_OUT_ENABLED;
			// enabled outputs idle in lp11 by default
			csi_lp11_hold <= run_q && ctrl_q[lst_pkg::LST_OUT_MODE_HI:
				lst_pkg::LST_OUT_MODE_LO] == lst_pkg::LST_OUT_ENABLED;
		end
	end

	// ------------------------------------------------------------
	// decoded writes toward paged blocks
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shared_wr  <= 1'b0;
			rxp_wr_en  <= 4'h0;
			csi_wr_en  <= 2'h0;
			page_addr  <= lst_pkg::LST_RESET_ZERO;
			page_wdata <= lst_pkg::LST_RESET_ZERO;
			rx_rd_sel  <= 2'h0;
			csi_rd_sel <= 1'b0;
		end else begin
			// either source reaches every block the same way
			shared_wr  <= reg_wr && wr_region == lst_pkg::LST_REG_SHARED;
			rxp_wr_en  <= (reg_wr && wr_region == lst_pkg::LST_REG_RXP) ?
				rx_page_q[3:0] : 4'h0;
			csi_wr_en  <= (reg_wr && wr_region == lst_pkg::LST_REG_CSI) ?
				csi_page_q[1:0] : 2'h0;
			page_addr  <= reg_addr;
			page_wdata <= reg_wdata;
			rx_rd_sel  <= rx_page_q[lst_pkg::LST_RX_RSEL_HI:
				lst_pkg::LST_RX_RSEL_LO];
			csi_rd_sel <= csi_page_q[lst_pkg::LST_CSI_RSEL_BIT];
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	logic [1:0] rsel;  // selected rx port for reads
	assign rsel = rx_page_q[lst_pkg::LST_RX_RSEL_HI:lst_pkg::LST_RX_RSEL_LO];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata    <= lst_pkg::LST_RESET_ZERO;
			reg_rvalid   <= 1'b0;
			reg_rsvd_hit <= 1'b0;
		end else begin
			reg_rvalid   <= reg_rd;
			reg_rsvd_hit <= (reg_rd || reg_wr) &&
				rd_region == lst_pkg::LST_REG_RSVD;
			if (reg_rd) begin
				case (reg_addr)
					lst_pkg::LST_CSI_PAGE_OFS:  reg_rdata <= csi_page_q;
					lst_pkg::LST_RX_PAGE_OFS:   reg_rdata <= rx_page_q;
					lst_pkg::LST_CONTROL_OFS:   reg_rdata <= ctrl_q;
					lst_pkg::LST_ERR_TALLY_OFS: reg_rdata <= tally[rsel];
					lst_pkg::LST_RX_DEBUG_OFS: begin
						reg_rdata <= {2'h0, far_active[rsel], 5'h00};
					end
					default: reg_rdata <= lst_pkg::LST_RESET_ZERO;
				endcase
			end
		end
	end

endmodule : lst_top
`default_nettype wire

// [tb/lst_checker.sv]
// lst_checker: port level assertions beside lst_top
// assumes: bound to lst_top, one clock, async active high reset
`timescale 1ns/1ns
`default_nettype none
module lst_checker (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid,
	input  wire logic       reg_rsvd_hit,
	input  wire logic       shared_wr,
	input  wire logic [7:0] page_wdata,
	input  wire logic [1:0] rx_rd_sel,
	input  wire logic       bc_wr,
	input  wire logic [7:0] bc_addr,
	input  wire logic [7:0] bc_wdata,
	input  wire logic       bc_ready,
	input  wire logic [3:0] rx_lock,
	input  wire logic [3:0] pattern_err,
	input  wire logic [3:0] pass_flag,
	input  wire logic       test_active,
	input  wire logic       video_out_en
);
	// ----------------
	// helper decode
	// ----------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire logic       rsvd_a = reg_addr inside {[8'h3b:8'h3f], [8'h80:8'h8f],
		[8'ha0:8'haf], [8'hc0:8'hcf], [8'he0:8'hef], [8'hf6:8'hf7],
		[8'hfc:8'hff]};       // reserved space
	wire logic       shrd_a = reg_addr inside {[8'h00:8'h31], [8'h40:8'h45],
		[8'h90:8'h9f], [8'hb0:8'hb2], [8'hb4:8'hbf], [8'hf0:8'hf5],
		[8'hf8:8'hfb]};       // shared blocks, page and control excluded
	wire logic [1:0] wsel = reg_wdata[5:4]; // rx read select field
	wire logic [1:0] wclk = reg_wdata[2:1]; // pattern clock field
	wire logic       ctl_w = reg_wr && reg_addr == 8'hb3 && !bc_wr;
	wire logic       start_w = ctl_w && reg_wdata[0] && !test_active;
	wire logic       stop_w = ctl_w && !reg_wdata[0] && test_active;
	// ----------------
	// back channel steps
	// ----------------
	sequence s_clk_taken;
		bc_wr && bc_addr == 8'h14 && bc_ready;
	endsequence
	sequence s_mode_on;
		bc_wr && bc_addr == 8'h15 && bc_wdata == 8'h01;
	endsequence
	// ----------------
	// assertions
	// ----------------
	AST_RD_ANSWER: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered next cycle");
	AST_RSVD_READ: assert property (reg_rd && rsvd_a |=>
		reg_rsvd_hit && reg_rdata == 8'h00)
		else $error("reserved read not flagged as zero");
	AST_SHARED_WR: assert property (reg_wr && shrd_a |=>
		shared_wr && page_wdata == $past(reg_wdata))
		else $error("shared block write not passed on");
	// the select is copied from the page register one cycle after it lands
	AST_RX_RSEL: assert property (reg_wr && reg_addr == 8'h4c |=>
		##1 rx_rd_sel == $past(wsel, 2))
		else $error("rx read select not taken");
	AST_START_CLK: assert property (start_w |=> bc_wr &&
		bc_addr == 8'h14 && bc_wdata == {5'h00, $past(wclk), 1'b0})
		else $error("start did not send clock select");
	AST_CLK_TO_MODE: assert property (s_clk_taken |=> s_mode_on)
		else $error("mode write did not follow clock write");
	AST_STOP_MODE: assert property (stop_w |=> bc_wr &&
		bc_addr == 8'h15 && bc_wdata == 8'h00)
		else $error("stop did not send mode off");
	AST_BC_HOLD: assert property (bc_wr && !bc_ready |=> bc_wr &&
		$stable(bc_addr) && $stable(bc_wdata))
		else $error("back channel request dropped early");
	AST_PASS_CAUSE: assert property (!(&pass_flag) |->
		($past(pattern_err) | $past(pattern_err, 2)) != 4'h0)
		else $error("pass flag low without an error");
	AST_IDLE_OUT: assert property (!test_active &&
		!$past(test_active) |-> video_out_en)
		else $error("outputs gated while idle");
	// each port lowers its own pass flag
	for (genvar i = 0; i < 4; i++) begin : g_pass
		AST_PASS_LOW: assert property (test_active && rx_lock[i] &&
			pattern_err[i] |-> ##[1:2] !pass_flag[i])
			else $error("pass flag not lowered after error");
	end
endmodule : lst_checker
bind lst_top lst_checker u_lst_checker (.clk(clk), .rst(rst),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.reg_rsvd_hit(reg_rsvd_hit), .shared_wr(shared_wr),
	.page_wdata(page_wdata), .rx_rd_sel(rx_rd_sel), .bc_wr(bc_wr),
	.bc_addr(bc_addr), .bc_wdata(bc_wdata), .bc_ready(bc_ready),
	.rx_lock(rx_lock), .pattern_err(pattern_err), .pass_flag(pass_flag),
	.test_active(test_active), .video_out_en(video_out_en));
`default_nettype wire

// [tb/lst_ser_model.sv]
// lst_ser_model: remote serializer behind the back channel
// assumes: requests held until bc_ready, one write per ready pulse
`timescale 1ns/1ns
`default_nettype none
module lst_ser_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [3:0] wait_n,     // cycles before accepting
	input  wire logic       bc_wr,      // write request
	input  wire logic [7:0] bc_addr,    // serializer register
	input  wire logic [7:0] bc_wdata,   // serializer data
	output logic            bc_ready,   // one cycle accept
	output logic [3:0]      far_active, // pattern running per port
	output logic [1:0]      clk_field   // register 0x14 bits 2:1
);
	logic [3:0] cnt_q;   // wait counter, slow answers
	logic [7:0] bc_errs; // back channel frames seen as bad
	// frames the far end cannot place count as errors
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bc_errs <= 8'h00;
		end else if (bc_wr && bc_ready && bc_addr != 8'h14 &&
			bc_addr != lst_pkg::LST_SER_MODE_REG) begin
			bc_errs <= bc_errs + 8'h01;
		end
	end
	// raise ready once wait_n cycles passed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 4'h0;
			bc_ready <= 1'b0;
		end else if (bc_wr && !bc_ready && cnt_q >= wait_n) begin
			bc_ready <= 1'b1;
		end else begin
			bc_ready <= 1'b0;
			cnt_q <= (bc_wr && !bc_ready) ? cnt_q + 4'h1 : 4'h0;
		end
	end
	// take the write at the edge where ready is high
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			far_active <= 4'h0;
			clk_field <= 2'h0;
		end else if (bc_wr && bc_ready) begin
			if (bc_addr == 8'h14) begin
				clk_field <= bc_wdata[2:1];
			end
			if (bc_addr == lst_pkg::LST_SER_MODE_REG) begin
				far_active <= {4{bc_wdata == lst_pkg::LST_SER_MODE_ON}};
			end
		end
	end
endmodule : lst_ser_model
`default_nettype wire

// [tb/link_selftest_page_select_bench.sv]
// link_selftest_page_select_bench: directed tests of lst_top
// assumes: lst_ser_model answers back channel, bench drives rx side
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
	n_mismatch++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module link_selftest_page_select_bench;
	// ----------------
	// signals
	// ----------------
	logic       clk = 1'b0, rst = 1'b1, src = 1'b0;
	logic       reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d;
	logic [3:0] rx_lock = 4'hf, pattern_err = 4'h0, wait_n = 4'h3;
	logic [7:0] reg_rdata, page_addr, page_wdata, bc_addr, bc_wdata;
	logic [3:0] rxp_wr_en, pass_flag, far_active;
	logic [1:0] csi_wr_en, rx_rd_sel, clk_field;
	logic       reg_rvalid, reg_rsvd_hit, shared_wr, csi_rd_sel;
	logic       bc_wr, bc_ready, test_active, video_out_en, csi_lp11_hold;
	int         n_tests = 0, n_mismatch = 0, cyc = 0;
	always #2 clk = ~clk; // 4 ns period
	lst_top dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_src_chan(src),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.reg_rsvd_hit(reg_rsvd_hit), .shared_wr(shared_wr),
		.rxp_wr_en(rxp_wr_en), .csi_wr_en(csi_wr_en), .rx_rd_sel(rx_rd_sel),
		.csi_rd_sel(csi_rd_sel), .page_addr(page_addr),
		.page_wdata(page_wdata), .bc_wr(bc_wr), .bc_addr(bc_addr),
		.bc_wdata(bc_wdata), .bc_ready(bc_ready), .rx_lock(rx_lock),
		.pattern_err(pattern_err), .far_active(far_active),
		.pass_flag(pass_flag), .test_active(test_active),
		.video_out_en(video_out_en), .csi_lp11_hold(csi_lp11_hold));
	lst_ser_model u_ser (.clk(clk), .rst(rst), .wait_n(wait_n),
		.bc_wr(bc_wr), .bc_addr(bc_addr), .bc_wdata(bc_wdata),
		.bc_ready(bc_ready), .far_active(far_active), .clk_field(clk_field));
	// ----------------
	// tasks
	// ----------------
	task automatic complete_run;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run
	// register write, sources alternate
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		src = ~src;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr
	// register read, data taken with the valid cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		src = ~src;
		@(negedge clk);
		reg_rd = 1'b0;
		v = reg_rdata;
	endtask : rd
	// wait for the back channel sequence to finish
	task automatic bc_idle;
		for (int i = 0; i < 60 && bc_wr !== 1'b0; i++) @(negedge clk);
		`CHK("bc_wr", 1'b0, bc_wr)
	endtask : bc_idle
	// pulse data errors on the masked ports
	task automatic errs(input logic [3:0] m, input int n);
		repeat (n) begin
			@(negedge clk);
			pattern_err = m;
			@(negedge clk);
			pattern_err = 4'h0;
		end
	endtask : errs
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			complete_run();
		end
	end
	// ----------------
	// tests
	// ----------------
	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		rd(8'h32, d); `CHK("csi_page", 8'h00, d)
		rd(8'h4c, d); `CHK("rx_page", 8'h00, d)
		rd(8'h3c, d); `CHK("rsvd_hit", 1'b1, reg_rsvd_hit)
		`CHK("video_en", 1'b1, video_out_en)
		$display("test reset done");
		wr(8'h4c, 8'h05); wr(8'h50, 8'h5a); `CHK("rx_wen", 4'h5, rxp_wr_en)
		`CHK("page_addr", 8'h50, page_addr)
		`CHK("page_wdata", 8'h5a, page_wdata)
		wr(8'hd4, 8'h11); `CHK("rx_dbg_wen", 4'h5, rxp_wr_en)
		wr(8'h32, 8'h13); wr(8'h35, 8'ha5); `CHK("csi_wen", 2'h3, csi_wr_en)
		`CHK("csi_rsel", 1'b1, csi_rd_sel)
		wr(8'h32, 8'h01); wr(8'h33, 8'h01); `CHK("csi_wen", 2'h1, csi_wr_en)
		wr(8'h10, 8'h3c); `CHK("shared_wr", 1'b1, shared_wr)
		wr(8'h4c, 8'h0f);
		$display("test decode done");
		wr(8'hb3, 8'h85); bc_idle(); // mode 10, clock 10
		`CHK("clk_field", 2'h2, clk_field)
		`CHK("active", 1'b1, test_active)
		`CHK("video_en", 1'b1, video_out_en)
		`CHK("lp11", 1'b1, csi_lp11_hold)
		rd(8'hd0, d); `CHK("far_act", 8'h20, d)
		errs(4'h2, 3);
		wr(8'h4c, 8'h1f); rd(8'h57, d); `CHK("tally1", 8'h03, d)
		wr(8'h4c, 8'h0f); rd(8'h57, d); `CHK("tally0", 8'h00, d)
		rx_lock = 4'hb; // port 2 drops lock
		wr(8'h4c, 8'h2f); rd(8'h57, d); `CHK("nolock", 8'hff, d)
		wr(8'hb3, 8'h83); bc_idle(); `CHK("frozen", 2'h2, clk_field)
		wr(8'hb3, 8'h00); bc_idle(); `CHK("active", 1'b0, test_active)
		rd(8'hd0, d); `CHK("far_act", 8'h00, d)
		$display("test run done");
		rx_lock = 4'hf;
		wait_n = 4'h0;
		wr(8'hb3, 8'h01); bc_idle(); `CHK("clk_field", 2'h0, clk_field)
		`CHK("video_en", 1'b0, video_out_en)
		wr(8'h4c, 8'h1f); rd(8'h57, d); `CHK("cleared", 8'h00, d)
		errs(4'h2, 260);
		rd(8'h57, d); `CHK("saturate", 8'hfe, d)
		wr(8'hb3, 8'h00); bc_idle();
		`CHK("bc_errs", 8'h00, u_ser.bc_errs)
		$display("test restart done");
		complete_run();
	end
endmodule : link_selftest_page_select_bench
`default_nettype wire
